// ### core/tsfb_cfg.svh
`ifndef TSFB_CFG_SVH
`define TSFB_CFG_SVH

// register word addresses, each word holds two bytes (offset 0 and 1)
`define TSFB_ADDR_FLAGS 8'h01
`define TSFB_ADDR_PAD 8'h02
`define TSFB_ADDR_POS 8'h03
`define TSFB_ADDR_TOUCH 8'h04

// system flags bit positions
`define TSFB_SYS_SHOW_RESET 7
`define TSFB_SYS_SEG_HOLD 6
`define TSFB_SYS_TUNE_FAULT 5
`define TSFB_SYS_NORMAL_SEG 3
`define TSFB_SYS_TUNE_BUSY 2
`define TSFB_SYS_IGNORE_HALT 1
`define TSFB_SYS_LOW_POWER 0

// event flags bit positions
`define TSFB_EVT_LOW_POWER 7
`define TSFB_EVT_SLIDE 5
`define TSFB_EVT_TAP 4
`define TSFB_EVT_TUNING 3
`define TSFB_EVT_PAD 2
`define TSFB_EVT_TOUCH 1
`define TSFB_EVT_PROX 0

// trackpad gesture flag bit positions
`define TSFB_PAD_ZONE_HI 7
`define TSFB_PAD_ZONE_LO 6
`define TSFB_PAD_RIGHT 5
`define TSFB_PAD_LEFT 4
`define TSFB_PAD_DOWN 3
`define TSFB_PAD_UP 2
`define TSFB_PAD_TAP 1
`define TSFB_PAD_IN_USE 0

// zone boundaries on the vertical axis and horizontal ceiling
`define TSFB_ZONE1_END 8'h55
`define TSFB_ZONE2_END 8'hAA
`define TSFB_X_MAX 8'h7F

// reset values
`define TSFB_RESET_SYS 8'h80
`define TSFB_RESET_BYTE 8'h00

`endif

// ### core/tsfb_pkg.sv
`default_nettype none

package tsfb_pkg;

    // levels reported by the sensing engine
    typedef struct packed {
        logic low_power;
        logic normal_seg;
        logic tuning_busy;
        logic tuning_fault;
        logic seg_hold;
        logic ignore_halt;
        logic pad_in_use;
        logic prox_ch0;
        logic [6:0] touch;
    } tsfb_status_t;

    // one-cycle event pulses from the sensing engine
    typedef struct packed {
        logic low_power_entry;
        logic slide;
        logic tap;
        logic tuning_done;
        logic pad_activity;
        logic touch_ev;
        logic prox_ev;
    } tsfb_event_t;

    // one-cycle gesture pulses from the gesture detector
    typedef struct packed {
        logic slide_right;
        logic slide_left;
        logic slide_down;
        logic slide_up;
        logic tap;
    } tsfb_gesture_t;

    // host access port
    typedef struct packed {
        logic rd_en;
        logic wr_en;
        logic [7:0] addr;
        logic offset;
        logic [7:0] wdata;
    } tsfb_host_req_t;

endpackage : tsfb_pkg

`default_nettype wire

// ### core/tsfb_bank.sv
// Behaviour
// - reset sets system flag bit 7; it stays until the host acknowledges
// - system bit 6 shows baseline averaging blocked in normal segment
// - system bit 5 shows a tuning error, zero otherwise
// - system bit 3 shows the normal-power segment is active
// - system bit 2 shows automatic tuning is running
// - system bit 1 shows the global baseline halt is ignored
// - system bit 0 shows low-power mode
// - event bit 7 set on low-power entry
// - event bit 5 set on a slide gesture
// - event bit 4 set on a tap gesture
// - event bit 3 set on a tuning event
// - event bit 2 set on a trackpad event
// - event bit 1 set on a touch event
// - event bit 0 set on a proximity event
// - pad bits 7:6 give zone: 00 none, 01/10/11 by vertical position
// - pad bits 5..2 set on slide right, left, down, up
// - pad bit 1 set on a tap, zero when none to report
// - pad bit 0 shows the trackpad is in use
// - horizontal position is unsigned, 0 to 127
// - vertical position is unsigned, 0 to 255
// - proximity byte bit 0 shows proximity on the wake channel
// - touch byte bits 6..0 show touch on channels 6..0
`timescale 1ns/1ps
`include "tsfb_cfg.svh"
`default_nettype none

module tsfb_bank
    import tsfb_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire tsfb_status_t status_in,
    input wire tsfb_event_t event_in,
    input wire tsfb_gesture_t gesture_in,
    input wire logic [7:0] horizontal_position_in,
    input wire logic [7:0] vertical_position_in,
    input wire logic position_valid_in,
    input wire logic reset_ack_in,
    input wire logic window_end_in,
    input wire logic clear_pad_flags_in,
    input wire tsfb_host_req_t host_req_in,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out
);

    logic [7:0] system_flags_r;
    logic [7:0] event_flags_r;
    logic [7:0] trackpad_gesture_flags_r;
    logic [7:0] horizontal_position_r;
    logic [7:0] vertical_position_r;
    logic [7:0] proximity_flag_byte_r;
    logic [7:0] touch_flag_byte_r;
    logic show_reset_r;
    logic [7:0] event_set;
    logic [4:0] gest_set;
    logic any_gesture;
    logic [7:0] rd_data_nxt;

    // zone code for a vertical position
    function automatic logic [1:0] zone_of(input logic [7:0] y);
        if (y < `TSFB_ZONE1_END)
            zone_of = 2'b01;
        else if (y < `TSFB_ZONE2_END)
            zone_of = 2'b10;
        else
            zone_of = 2'b11;
    endfunction : zone_of

    // read mux shared by the host port
    function automatic logic [7:0] pick(input logic [7:0] lo, input logic [7:0] hi,
                                        input logic off);
        pick = off ? hi : lo;
    endfunction : pick

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            show_reset_r <= 1'b1;
        else if (reset_ack_in)
            show_reset_r <= 1'b0;
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            system_flags_r <= `TSFB_RESET_SYS;
        else
        begin
            system_flags_r <= `TSFB_RESET_BYTE;
            system_flags_r[`TSFB_SYS_SHOW_RESET] <= show_reset_r & ~reset_ack_in;
            system_flags_r[`TSFB_SYS_SEG_HOLD] <= status_in.seg_hold;
            system_flags_r[`TSFB_SYS_TUNE_FAULT] <= status_in.tuning_fault;
            system_flags_r[`TSFB_SYS_NORMAL_SEG] <= status_in.normal_seg;
            system_flags_r[`TSFB_SYS_TUNE_BUSY] <= status_in.tuning_busy;
            system_flags_r[`TSFB_SYS_IGNORE_HALT] <= status_in.ignore_halt;
            system_flags_r[`TSFB_SYS_LOW_POWER] <= status_in.low_power;
        end
    end

    always_comb
    begin
        event_set = `TSFB_RESET_BYTE;
        event_set[`TSFB_EVT_LOW_POWER] = event_in.low_power_entry;
        event_set[`TSFB_EVT_SLIDE] = event_in.slide;
        event_set[`TSFB_EVT_TAP] = event_in.tap;
        event_set[`TSFB_EVT_TUNING] = event_in.tuning_done;
        event_set[`TSFB_EVT_PAD] = event_in.pad_activity;
        event_set[`TSFB_EVT_TOUCH] = event_in.touch_ev;
        event_set[`TSFB_EVT_PROX] = event_in.prox_ev;
    end

    // sticky events: cleared at window end, a new event wins over the clear
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            event_flags_r <= `TSFB_RESET_BYTE;
        else if (window_end_in)
            event_flags_r <= event_set;
        else
            event_flags_r <= event_flags_r | event_set;
    end

    assign gest_set = {gesture_in.slide_right, gesture_in.slide_left,
                       gesture_in.slide_down, gesture_in.slide_up, gesture_in.tap};
    assign any_gesture = |gest_set;

    // gesture flags stay until a new gesture, or until window end when clearing is on
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            trackpad_gesture_flags_r <= `TSFB_RESET_BYTE;
        else
        begin
            trackpad_gesture_flags_r[`TSFB_PAD_IN_USE] <= status_in.pad_in_use;
            if (any_gesture)
            begin
                // zone taken from the position at the gesture
                trackpad_gesture_flags_r[`TSFB_PAD_ZONE_HI:`TSFB_PAD_ZONE_LO] <=
                    zone_of(vertical_position_in);
                trackpad_gesture_flags_r[`TSFB_PAD_RIGHT:`TSFB_PAD_TAP] <= gest_set;
            end
            else if (window_end_in && clear_pad_flags_in)
                trackpad_gesture_flags_r[`TSFB_PAD_ZONE_HI:`TSFB_PAD_TAP] <= 7'h00;
        end
    end

    // positions sampled when the engine offers a new point
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            horizontal_position_r <= `TSFB_RESET_BYTE;
            vertical_position_r <= `TSFB_RESET_BYTE;
        end
        else if (position_valid_in)
        begin
            horizontal_position_r <= (horizontal_position_in > `TSFB_X_MAX) ?
                                     `TSFB_X_MAX : horizontal_position_in;
            vertical_position_r <= vertical_position_in;
        end
    end

    // channel levels, spare bits forced low
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            proximity_flag_byte_r <= `TSFB_RESET_BYTE;
            touch_flag_byte_r <= `TSFB_RESET_BYTE;
        end
        else
        begin
            proximity_flag_byte_r <= {7'h00, status_in.prox_ch0};
            touch_flag_byte_r <= {1'b0, status_in.touch};
        end
    end

    // writes are never decoded; unmapped reads return zero
    always_comb
    begin
        case (host_req_in.addr)
            `TSFB_ADDR_FLAGS: rd_data_nxt = pick(system_flags_r, event_flags_r,
                                                 host_req_in.offset);
            `TSFB_ADDR_PAD: rd_data_nxt = host_req_in.offset ? `TSFB_RESET_BYTE :
                                          trackpad_gesture_flags_r;
            `TSFB_ADDR_POS: rd_data_nxt = pick(horizontal_position_r, vertical_position_r,
                                               host_req_in.offset);
            `TSFB_ADDR_TOUCH: rd_data_nxt = pick(proximity_flag_byte_r, touch_flag_byte_r,
                                                 host_req_in.offset);
            default: rd_data_nxt = `TSFB_RESET_BYTE;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rd_data_out <= `TSFB_RESET_BYTE;
            rd_valid_out <= 1'b0;
        end
        else
        begin
            rd_valid_out <= host_req_in.rd_en;
            if (host_req_in.rd_en)
                rd_data_out <= rd_data_nxt;
        end
    end

    a_show_reset_hold: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (show_reset_r && !reset_ack_in) |=> system_flags_r[`TSFB_SYS_SHOW_RESET])
        else $error("show reset dropped without acknowledge");

    a_low_power_level: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        1'b1 |=> system_flags_r[`TSFB_SYS_LOW_POWER] == $past(status_in.low_power))
        else $error("low power bit does not follow mode");

    a_tune_busy_level: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        status_in.tuning_busy |=> system_flags_r[`TSFB_SYS_TUNE_BUSY])
        else $error("tuning busy bit missing");

    a_event_sticky: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        event_in.low_power_entry |=> event_flags_r[`TSFB_EVT_LOW_POWER]
            ##1 (event_flags_r[`TSFB_EVT_LOW_POWER] || $past(window_end_in)))
        else $error("low power event flag lost");

    a_slide_event: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (event_in.slide && window_end_in) |=> event_flags_r[`TSFB_EVT_SLIDE])
        else $error("slide event lost to clear");

    a_prox_event: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        event_in.prox_ev |=> event_flags_r[`TSFB_EVT_PROX])
        else $error("proximity event flag missing");

    a_zone_code: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (gesture_in.tap && vertical_position_in >= `TSFB_ZONE2_END) |=>
            trackpad_gesture_flags_r[`TSFB_PAD_ZONE_HI:`TSFB_PAD_ZONE_LO] == 2'b11)
        else $error("top zone code wrong");

    a_tap_flag: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        gesture_in.tap |=> trackpad_gesture_flags_r[`TSFB_PAD_TAP]
            ##1 (trackpad_gesture_flags_r[`TSFB_PAD_TAP] || $past(window_end_in)
                 || $past(any_gesture)))
        else $error("tap flag not held");

    a_x_range: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        horizontal_position_r <= `TSFB_X_MAX)
        else $error("horizontal position out of range");

    a_spare_zero: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        !system_flags_r[4] && !event_flags_r[6] && !touch_flag_byte_r[7]
            && proximity_flag_byte_r[7:1] == 7'h00)
        else $error("unassigned bit reads one");

    a_touch_follow: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        1'b1 |=> touch_flag_byte_r[6:0] == $past(status_in.touch))
        else $error("touch bits do not follow channels");

    a_read_data: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (host_req_in.rd_en && host_req_in.addr == `TSFB_ADDR_TOUCH && host_req_in.offset)
            |=> rd_valid_out && rd_data_out == $past(touch_flag_byte_r))
        else $error("touch byte read wrong");

    a_seg_hold_level: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        1'b1 |=> system_flags_r[`TSFB_SYS_SEG_HOLD] == $past(status_in.seg_hold))
        else $error("segment hold bit does not follow engine");

    a_tune_fault_level: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        1'b1 |=> system_flags_r[`TSFB_SYS_TUNE_FAULT] == $past(status_in.tuning_fault))
        else $error("tuning fault bit does not follow engine");

    a_normal_seg_level: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        1'b1 |=> system_flags_r[`TSFB_SYS_NORMAL_SEG] == $past(status_in.normal_seg))
        else $error("normal segment bit does not follow engine");

    a_ignore_halt_level: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        1'b1 |=> system_flags_r[`TSFB_SYS_IGNORE_HALT] == $past(status_in.ignore_halt))
        else $error("ignore halt bit does not follow engine");

    a_tap_event: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        event_in.tap |=> event_flags_r[`TSFB_EVT_TAP])
        else $error("tap event flag missing");

    a_tuning_event: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        event_in.tuning_done |=> event_flags_r[`TSFB_EVT_TUNING])
        else $error("tuning event flag missing");

    a_pad_event: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        event_in.pad_activity |=> event_flags_r[`TSFB_EVT_PAD])
        else $error("trackpad event flag missing");

    a_touch_event: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        event_in.touch_ev |=> event_flags_r[`TSFB_EVT_TOUCH])
        else $error("touch event flag missing");

    a_event_clear: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (window_end_in && !event_in.prox_ev) |=> !event_flags_r[`TSFB_EVT_PROX])
        else $error("proximity event flag not cleared at window end");

    a_gesture_bits: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        any_gesture |=> trackpad_gesture_flags_r[`TSFB_PAD_RIGHT:`TSFB_PAD_TAP] == $past(gest_set))
        else $error("gesture bits do not match gesture");

    a_pad_clear: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (window_end_in && clear_pad_flags_in && !any_gesture) |=>
            trackpad_gesture_flags_r[`TSFB_PAD_ZONE_HI:`TSFB_PAD_TAP] == 7'h00)
        else $error("gesture flags not cleared at window end");

    a_pad_in_use: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        1'b1 |=> trackpad_gesture_flags_r[`TSFB_PAD_IN_USE] == $past(status_in.pad_in_use))
        else $error("trackpad in use bit does not follow engine");

    a_x_clamp: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (position_valid_in && horizontal_position_in > `TSFB_X_MAX) |=>
            horizontal_position_r == `TSFB_X_MAX)
        else $error("horizontal position not clamped");

    a_y_follow: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        position_valid_in |=> vertical_position_r == $past(vertical_position_in))
        else $error("vertical position not taken");

    a_prox_level: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        1'b1 |=> proximity_flag_byte_r[0] == $past(status_in.prox_ch0))
        else $error("proximity bit does not follow channel");

    a_read_valid: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        1'b1 |=> rd_valid_out == $past(host_req_in.rd_en))
        else $error("read valid does not follow read request");

    a_write_ignored: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (host_req_in.wr_en && !host_req_in.rd_en) |=> !rd_valid_out && $stable(rd_data_out))
        else $error("write changed the read port");

    a_system_read: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (host_req_in.rd_en && host_req_in.addr == `TSFB_ADDR_FLAGS && !host_req_in.offset)
            |=> rd_data_out == $past(system_flags_r))
        else $error("system flags read wrong");

endmodule : tsfb_bank

`default_nettype wire

// ### tb/tsfb_host.sv
`timescale 1ns/1ps
`default_nettype none

module tsfb_host
    import tsfb_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic [7:0] rd_data_in,
    input wire logic rd_valid_in,
    output tsfb_host_req_t host_req_out
);
    initial host_req_out = '0;

    // request stands over one rising edge; answer is looked at one cycle later
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic off,
        input logic [7:0] wd, output logic [7:0] rd);
        @(negedge clk_sys_in);
        host_req_out = {~wr, wr, addr, off, wd};
        @(negedge clk_sys_in);
        // no valid strobe means no data: report unknown so a compare fails
        rd = (rd_valid_in === 1'b1) ? rd_data_in : 8'hxx;
        host_req_out = '0;
    endtask : xfer
endmodule : tsfb_host

`default_nettype wire

// ### tb/touch_status_flag_bank_bench.sv
`timescale 1ns/1ps
`default_nettype none

module touch_status_flag_bank_bench;
    import tsfb_pkg::*;
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
    $display("mismatch t=%0t got %h exp %h", $time, a, b); end end

    logic clk_sys_in;
    logic reset_n_in;
    tsfb_status_t st;
    tsfb_event_t ev;
    tsfb_gesture_t ge;
    logic [7:0] x;
    logic [7:0] y;
    logic pv;
    logic ack;
    logic wend;
    logic clrp;
    tsfb_host_req_t req;
    logic [7:0] rd_data;
    logic rd_valid;
    int n_mismatch = 0;
    int compares = 0;
    int i;
    logic [7:0] exp;
    logic [7:0] d;
    logic [7:0] ys [5] = '{8'h00, 8'h54, 8'h55, 8'hA9, 8'hAA};
    logic [7:0] zs [5] = '{8'h40, 8'h40, 8'h80, 8'h80, 8'hC0};

    tsfb_bank uut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .status_in(st),
        .event_in(ev), .gesture_in(ge), .horizontal_position_in(x),
        .vertical_position_in(y), .position_valid_in(pv), .reset_ack_in(ack),
        .window_end_in(wend), .clear_pad_flags_in(clrp), .host_req_in(req),
        .rd_data_out(rd_data), .rd_valid_out(rd_valid));

    tsfb_host h (.clk_sys_in(clk_sys_in), .rd_data_in(rd_data), .rd_valid_in(rd_valid),
        .host_req_out(req));

    initial
    begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end

    task automatic chk_rd(input logic [7:0] a, input logic o, input logic [7:0] e);
        logic [7:0] r;
        h.xfer(1'b0, a, o, 8'h00, r);
        `CHK(r, e)
    endtask : chk_rd

    // engine strobes stand for exactly one cycle
    task automatic pulse(input tsfb_event_t e, input tsfb_gesture_t g, input logic a,
        input logic w);
        @(negedge clk_sys_in);
        ev = e;
        ge = g;
        ack = a;
        wend = w;
        @(negedge clk_sys_in);
        ev = '0;
        ge = '0;
        ack = 1'b0;
        wend = 1'b0;
    endtask : pulse

    task final_report;
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report

    initial
    begin
        #(25 * 3000);
        n_mismatch++;
        final_report();
    end

    initial
    begin
        reset_n_in = 1'b0;
        st = '0;
        ev = '0;
        ge = '0;
        x = 8'h00;
        y = 8'h00;
        pv = 1'b0;
        ack = 1'b0;
        wend = 1'b0;
        clrp = 1'b0;
        repeat (2) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        reset_n_in = 1'b1;
        chk_rd(8'h01, 1'b0, 8'h80);
        // every other byte, plus unmapped places, reads zero
        for (i = 3; i < 12; i++)
            chk_rd(8'(i / 2), i[0], 8'h00);
        h.xfer(1'b1, 8'h01, 1'b0, 8'hFF, d);
        h.xfer(1'b1, 8'h04, 1'b1, 8'hFF, d);
        chk_rd(8'h01, 1'b0, 8'h80);
        chk_rd(8'h04, 1'b1, 8'h00);
        pulse('0, '0, 1'b1, 1'b0);
        chk_rd(8'h01, 1'b0, 8'h00);
        for (i = 0; i < 2; i++)
        begin
            @(negedge clk_sys_in);
            st = i ? {8'h55, 7'h2A} : {8'hAA, 7'h55};
            chk_rd(8'h01, 1'b0, i ? 8'h2A : 8'h45);
            chk_rd(8'h02, 1'b0, i ? 8'h00 : 8'h01);
            chk_rd(8'h04, 1'b0, i ? 8'h01 : 8'h00);
            chk_rd(8'h04, 1'b1, i ? 8'h2A : 8'h55);
        end
        st = '0;
        exp = 8'h00;
        for (i = 0; i < 7; i++)
        begin
            pulse(7'(1 << i), '0, 1'b0, 1'b0);
            exp = exp | ((i == 6) ? 8'h80 : 8'(1 << i));
            chk_rd(8'h01, 1'b1, exp);
        end
        // a new event in the clearing cycle survives it
        pulse(7'h30, '0, 1'b0, 1'b1);
        chk_rd(8'h01, 1'b1, 8'h30);
        pulse('0, '0, 1'b0, 1'b1);
        chk_rd(8'h01, 1'b1, 8'h00);
        for (i = 0; i < 5; i++)
        begin
            @(negedge clk_sys_in);
            y = ys[i];
            pulse('0, 5'(1 << i), 1'b0, 1'b0);
            chk_rd(8'h02, 1'b0, zs[i] | 8'(2 << i));
        end
        pulse('0, '0, 1'b0, 1'b1);
        chk_rd(8'h02, 1'b0, 8'hE0);
        clrp = 1'b1;
        pulse('0, '0, 1'b0, 1'b1);
        chk_rd(8'h02, 1'b0, 8'h00);
        // tap high on the pad lands in the top zone
        y = 8'hC8;
        pulse('0, 5'h01, 1'b0, 1'b0);
        chk_rd(8'h02, 1'b0, 8'hC2);
        @(negedge clk_sys_in);
        x = 8'h80;
        y = 8'hFF;
        pv = 1'b1;
        @(negedge clk_sys_in);
        pv = 1'b0;
        x = 8'h11;
        y = 8'h22;
        chk_rd(8'h03, 1'b0, 8'h7F);
        chk_rd(8'h03, 1'b1, 8'hFF);
        @(negedge clk_sys_in);
        reset_n_in = 1'b0;
        @(negedge clk_sys_in);
        reset_n_in = 1'b1;
        chk_rd(8'h01, 1'b0, 8'h80);
        chk_rd(8'h03, 1'b0, 8'h00);
        final_report();
    end
endmodule : touch_status_flag_bank_bench

`default_nettype wire
